// ===== mta_consts.svh
// Purpose: Register offsets, control fields and fixed values of the timer.
// Assumes: Included by the top module and the checker.
// Notes:   Definitions only.
`ifndef MTA_CONSTS_SVH
`define MTA_CONSTS_SVH
`define MTA_OFF_CTRL  8'h00
`define MTA_OFF_ACNT  8'h04
`define MTA_OFF_BCNT  8'h08
`define MTA_OFF_BREL  8'h0C
`define MTA_OFF_IRQ   8'h10
`define MTA_ADDR_W    8
`define MTA_CTRL_RST  8'h00
`define MTA_BIT_ASTART 0
`define MTA_BIT_BSTART 1
`define MTA_AMODE_HI  3
`define MTA_AMODE_LO  2
`define MTA_BMODE_HI  5
`define MTA_BMODE_LO  4
`define MTA_BIT_AUP   6
`define MTA_BIT_AFREE 7
`define MTA_IRQ_A     0
`define MTA_IRQ_B     1
`define MTA_ALL_ONES  16'hFFFF
`define MTA_ZERO      16'h0000
`define MTA_ONE       16'h0001
`endif

// ===== mta_pkg.sv
// Purpose: Types shared by the timer design.
// Assumes: Mode fields are two bits wide in the control register.
// Notes:   Enum order matches the control field encoding.
package mta_pkg;
    typedef enum logic [1:0] {
        MTA_A_TIMER,
        MTA_A_EVENT,
        MTA_A_ONESHOT,
        MTA_A_PWM
    } mta_amode_e;
    typedef enum logic [1:0] {
        MTA_B_TIMER,
        MTA_B_EVENT,
        MTA_B_PERIOD,
        MTA_B_WIDTH
    } mta_bmode_e;
endpackage

// ===== mta_timer_ab.sv
// Purpose: Two-group 16-bit multifunction timer with an APB register slave.
// Assumes: One clock sys_clk at 100 MHz, synchronous active-high reset.
// Notes:   Pins are synchronised by two flip-flops before use.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mta_consts.svh"
module mta_timer_ab
    import mta_pkg::*;
#(
    parameter int TICK_DIV = 1
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`MTA_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   a_event_pin,
    input  wire logic                   b_event_pin,
    output var  logic                   group_a_timer_output_pin,
    output var  logic                   a_irq_req,
    output var  logic                   b_irq_req
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
        $error("TICK_DIV must lie in 1..65535.");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_reg;
    logic [1:0]  irq_reg;
    logic [15:0] div_reg;
    logic        tick;
    logic [2:0]  a_sync_reg;
    logic [2:0]  b_sync_reg;
    logic        a_edge;
    logic        b_rise;
    logic        b_fall;
    logic [15:0] a_cnt_reg;
    logic [15:0] a_rel_reg;
    logic        a_out_reg;
    logic        a_run_reg;
    logic        a_start_prev_reg;
    logic [15:0] b_cnt_reg;
    logic [15:0] b_rel_reg;
    logic        b_first_reg;
    logic        b_start_prev_reg;
    mta_amode_e  a_mode;
    mta_bmode_e  b_mode;
    logic        a_start;
    logic        b_start;
    logic        a_up;
    logic        a_free;
    logic        acc;
    logic        wr;
    logic        a_start_rise;
    logic        a_start_fall;
    logic        b_start_rise;
    logic        a_reload_now;
    logic        a_over_now;
    logic        b_reload_now;
    logic        b_meas_edge;
    logic [15:0] a_pwm_next;
    logic        a_event;
    logic        b_event;
    logic        a_mode_hit;
    logic        b_mode_hit;
    logic [7:0]  new_ctrl;

    // Address decode used only by the error flag.
    function automatic logic mapped(input logic [`MTA_ADDR_W-1:0] a);
        return a == `MTA_OFF_CTRL || a == `MTA_OFF_ACNT || a == `MTA_OFF_BCNT
            || a == `MTA_OFF_BREL || a == `MTA_OFF_IRQ;
    endfunction

    // ----------------------------------------------------------------
    // Field views and event decode
    // ----------------------------------------------------------------
    assign a_mode   = mta_amode_e'(ctrl_reg[`MTA_AMODE_HI:`MTA_AMODE_LO]);
    assign b_mode   = mta_bmode_e'(ctrl_reg[`MTA_BMODE_HI:`MTA_BMODE_LO]);
    assign a_start  = ctrl_reg[`MTA_BIT_ASTART];
    assign b_start  = ctrl_reg[`MTA_BIT_BSTART];
    assign a_up     = ctrl_reg[`MTA_BIT_AUP];
    assign a_free   = ctrl_reg[`MTA_BIT_AFREE];
    assign acc      = psel && penable && pready;
    assign wr       = acc && pwrite;
    assign new_ctrl = pwdata[7:0];
    assign a_start_rise = a_start && !a_start_prev_reg;
    assign a_start_fall = !a_start && a_start_prev_reg;
    assign b_start_rise = b_start && !b_start_prev_reg;
    // Pin edges look only at the second and third stages.
    assign a_edge = a_sync_reg[1] && !a_sync_reg[2];
    assign b_rise = b_sync_reg[1] && !b_sync_reg[2];
    assign b_fall = !b_sync_reg[1] && b_sync_reg[2];
    assign b_meas_edge = (b_mode == MTA_B_WIDTH) ? (b_rise || b_fall) : b_rise;
    assign a_pwm_next  = a_cnt_reg + `MTA_ONE;

    // Reload instants; a read at such an edge sees the boundary value.
    always_comb begin
        a_reload_now = 1'b0;
        a_over_now   = 1'b0;
        case (a_mode)
            MTA_A_TIMER: a_reload_now = a_start && tick && a_cnt_reg == `MTA_ZERO;
            MTA_A_EVENT: begin
                a_over_now   = a_up && a_cnt_reg == `MTA_ALL_ONES;
                a_reload_now = a_start && a_edge && !a_free
                    && (a_over_now || (!a_up && a_cnt_reg == `MTA_ZERO));
            end
            MTA_A_ONESHOT: a_reload_now = a_run_reg && tick && a_cnt_reg == `MTA_ZERO;
            default: a_reload_now = 1'b0;
        endcase
    end

    assign b_reload_now = b_start && b_cnt_reg == `MTA_ZERO
        && ((b_mode == MTA_B_TIMER && tick) || (b_mode == MTA_B_EVENT && b_rise));

    // Request sources of each group, spurious mode-change ones included.
    always_comb begin
        a_event = 1'b0;
        case (a_mode)
            MTA_A_TIMER, MTA_A_EVENT: a_event = a_reload_now;
            MTA_A_ONESHOT: a_event = a_reload_now || (a_start_fall && a_run_reg);
            MTA_A_PWM: a_event = (a_start_fall && a_out_reg)
                || (a_start && tick && a_out_reg && a_pwm_next >= a_rel_reg);
            default: a_event = 1'b0;
        endcase
    end

    // Reset leaves timer mode, so the first selection counts as a change.
    assign a_mode_hit = wr && paddr == `MTA_OFF_CTRL
        && (a_mode == MTA_A_TIMER || a_mode == MTA_A_EVENT)
        && new_ctrl[`MTA_AMODE_HI];
    assign b_mode_hit = wr && paddr == `MTA_OFF_CTRL && b_start
        && b_mode[1] && new_ctrl[`MTA_BMODE_HI]
        && new_ctrl[`MTA_BMODE_LO] != b_mode[0];
    assign b_event = b_reload_now || b_mode_hit
        || (b_start && b_mode[1] && b_meas_edge && !b_first_reg);

    // ----------------------------------------------------------------
    // Count-rate divider and pin synchronisers
    // ----------------------------------------------------------------
    // The tick is a one-cycle enable; counters never run on a slower clock.
    always_ff @(posedge sys_clk) begin
        if (reset || div_reg == 16'(TICK_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end
    assign tick = !reset && div_reg == 16'(TICK_DIV - 1);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            a_sync_reg <= '0;
            b_sync_reg <= '0;
        end else begin
            a_sync_reg <= {a_sync_reg[1:0], a_event_pin};
            b_sync_reg <= {b_sync_reg[1:0], b_event_pin};
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Read data is sampled in the setup cycle, write data in the access cycle; access completes in one cycle.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata  <= '0;
            if (!pwrite) begin
                case (paddr)
                    `MTA_OFF_CTRL: prdata[7:0] <= ctrl_reg;
                    `MTA_OFF_ACNT: prdata[15:0] <= !a_reload_now ? a_cnt_reg
                        : (a_over_now ? `MTA_ZERO : `MTA_ALL_ONES);
                    `MTA_OFF_BCNT: prdata[15:0] <= b_reload_now
                        ? `MTA_ALL_ONES : b_cnt_reg;
                    `MTA_OFF_BREL: prdata[15:0] <= b_rel_reg;
                    `MTA_OFF_IRQ:  prdata[1:0] <= irq_reg;
                    default:       prdata <= '0;
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control register.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_reg         <= `MTA_CTRL_RST;
            a_start_prev_reg <= 1'b0;
            b_start_prev_reg <= 1'b0;
        end else begin
            a_start_prev_reg <= a_start;
            b_start_prev_reg <= b_start;
            if (wr && paddr == `MTA_OFF_CTRL) begin
                ctrl_reg <= new_ctrl;
            end
        end
    end

    // Request bits: write one to clear, a new request wins the same edge.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_reg <= '0;
        end else begin
            if (wr && paddr == `MTA_OFF_IRQ) begin
                irq_reg <= irq_reg & ~pwdata[1:0];
            end
            if (a_event || a_mode_hit) begin
                irq_reg[`MTA_IRQ_A] <= 1'b1;
            end
            if (b_event) begin
                irq_reg[`MTA_IRQ_B] <= 1'b1;
            end
        end
    end
    assign a_irq_req = irq_reg[`MTA_IRQ_A];
    assign b_irq_req = irq_reg[`MTA_IRQ_B];

    // ----------------------------------------------------------------
    // Group A counter
    // ----------------------------------------------------------------
    // A free-running event counter keeps wrapping; software must reload
    // it after a stop, since nothing here restores the count.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            a_cnt_reg <= '0;
            a_rel_reg <= '0;
            a_out_reg <= 1'b0;
            a_run_reg <= 1'b0;
        end else begin
            case (a_mode)
                MTA_A_TIMER: begin
                    a_out_reg <= 1'b0;
                    if (a_start && tick) begin
                        a_cnt_reg <= a_reload_now ? a_rel_reg : a_cnt_reg - `MTA_ONE;
                    end
                end
                MTA_A_EVENT: begin
                    a_out_reg <= 1'b0;
                    if (a_start && a_edge) begin
                        if (a_reload_now) begin
                            a_cnt_reg <= a_rel_reg;
                        end else if (a_up) begin
                            a_cnt_reg <= a_cnt_reg + `MTA_ONE;
                        end else begin
                            a_cnt_reg <= a_cnt_reg - `MTA_ONE;
                        end
                    end
                end
                MTA_A_ONESHOT: begin
                    if (a_start_rise) begin
                        a_cnt_reg <= a_rel_reg;
                        a_run_reg <= 1'b1;
                        a_out_reg <= 1'b1;
                    end else if (a_start_fall && a_run_reg) begin
                        a_run_reg <= 1'b0;
                        a_cnt_reg <= a_rel_reg;
                        a_out_reg <= 1'b0;
                    end else if (a_reload_now) begin
                        a_run_reg <= 1'b0;
                        a_cnt_reg <= a_rel_reg;
                        a_out_reg <= 1'b0;
                    end else if (a_run_reg && tick) begin
                        a_cnt_reg <= a_cnt_reg - `MTA_ONE;
                    end
                end
                MTA_A_PWM: begin
                    a_run_reg <= 1'b0;
                    if (a_start_fall && a_out_reg) begin
                        a_out_reg <= 1'b0;
                    end else if (a_start && tick) begin
                        a_cnt_reg <= a_pwm_next;
                        a_out_reg <= a_pwm_next < a_rel_reg;
                    end
                end
                default: a_out_reg <= 1'b0;
            endcase
            // A halted counter takes the written value so it reads back.
            if (wr && paddr == `MTA_OFF_ACNT) begin
                a_rel_reg <= pwdata[15:0];
                if (!a_start) begin
                    a_cnt_reg <= pwdata[15:0];
                end
            end
        end
    end
    assign group_a_timer_output_pin = a_out_reg;

    // ----------------------------------------------------------------
    // Group B counter
    // ----------------------------------------------------------------
    // Measurement counts up and captures on each active edge; the first
    // capture holds a meaningless span and raises no request.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            b_cnt_reg   <= '0;
            b_rel_reg   <= '0;
            b_first_reg <= 1'b0;
        end else begin
            if (b_start_rise) begin
                b_first_reg <= 1'b1;
            end
            if (b_start && (b_mode == MTA_B_TIMER ? tick : b_rise)
                && !b_mode[1]) begin
                b_cnt_reg <= b_reload_now ? b_rel_reg : b_cnt_reg - `MTA_ONE;
            end else if (b_start && b_mode[1]) begin
                if (b_meas_edge) begin
                    b_rel_reg   <= b_cnt_reg;
                    b_cnt_reg   <= `MTA_ZERO;
                    b_first_reg <= 1'b0;
                end else if (tick) begin
                    b_cnt_reg <= b_cnt_reg + `MTA_ONE;
                end
            end
            if (wr && paddr == `MTA_OFF_BCNT) begin
                b_rel_reg <= pwdata[15:0];
                if (!b_start) begin
                    b_cnt_reg <= pwdata[15:0];
                end
            end
        end
    end
endmodule // mta_timer_ab
`default_nettype wire

// ===== mta_timer_ab_checker.sv
// Purpose: Port-level assertions for the two-group timer.
// Assumes: Sees only the top ports; CTRL writes are shadowed locally.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
`include "mta_consts.svh"
module mta_timer_ab_checker (
    input wire logic                   sys_clk,
    input wire logic                   reset,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`MTA_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   group_a_timer_output_pin,
    input wire logic                   a_irq_req,
    input wire logic                   b_irq_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Control shadow
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic       wr_ctrl;
    logic       pin;
    // The old mode is needed to tell a mode change from a rewrite.
    assign wr_ctrl = psel && penable && pready && pwrite && paddr == `MTA_OFF_CTRL;
    assign pin = group_a_timer_output_pin;
    // Follows software writes so checks know the mode in force.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_reg <= 8'h00;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata[7:0];
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ready_setup: assert property (psel && !penable |=> pready && penable)
        else $error("pready missing in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    a_err_unmapped: assert property (pready && (paddr > `MTA_OFF_IRQ || paddr[1:0] != 2'b00)
        |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !pin && !a_irq_req && !b_irq_req)
        else $error("outputs not cleared by reset");
    a_mode_irq: assert property (wr_ctrl && !ctrl_reg[3] && pwdata[3] |-> ##[1:3] a_irq_req)
        else $error("entering one-shot or pwm did not raise request");
    a_abort_low: assert property (wr_ctrl && ctrl_reg[0] && ctrl_reg[3] && !pwdata[0] && pin
        && pwdata[3:2] == ctrl_reg[3:2] |-> ##[1:3] (a_irq_req && !pin))
        else $error("stop while high did not drop pin with request");
    a_pwm_hold: assert property (wr_ctrl && ctrl_reg[3:0] == 4'b1101 && pwdata[3:0] == 4'b1100
        && !pin |=> !pin [*3]) else $error("pwm stop while low moved pin");
    a_bsel_irq: assert property (wr_ctrl && ctrl_reg[1] && ctrl_reg[5] && pwdata[1] && pwdata[5]
        && pwdata[4] != ctrl_reg[4] |-> ##[1:3] b_irq_req)
        else $error("measurement select change did not raise request");
endmodule // mta_timer_ab_checker
`default_nettype wire

// ===== mta_timer_ab_bench.sv
// Purpose: Self-checking bench for the two-group timer.
// Assumes: APB master waits for pready; only the watchdog ends a hang.
// Notes:   Flags are checked a few cycles after the write or pin pulse that causes them.
`timescale 1ns/1ps
`default_nettype none
module mta_timer_ab_bench;
    import mta_pkg::*;
    logic        sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, v;
    logic        pready, pslverr, out_pin, a_irq, b_irq, er;
    logic        a_pin = 1'b0, b_pin = 1'b0;
    logic [15:0] mt [4] = '{16'h0008, 16'h0408, 16'h000C, 16'h040C};
    int          err_total = 0, tests_run = 0, hits = 0;
    mta_timer_ab dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .a_event_pin(a_pin), .b_event_pin(b_pin),
        .group_a_timer_output_pin(out_pin), .a_irq_req(a_irq), .b_irq_req(b_irq));
    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Holds the request until pready is sampled high, then releases it.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask
    task automatic settle();
        repeat (5) @(posedge sys_clk);
    endtask
    // Edges reach the counter only after synchronisation, hence the waits.
    task automatic pulse(input logic b);
        @(posedge sys_clk);
        {b_pin, a_pin} <= b ? 2'b10 : 2'b01;
        repeat (4) @(posedge sys_clk);
        {b_pin, a_pin} <= 2'b00;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic wait_out();
        int n;
        n = 0;
        while (out_pin !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        chk("out high", 32'h0000_0001, out_pin);
    endtask
    task automatic wrap_up();
        $display("Checks run %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        rdc("ctrl", 8'h00, 32'h0000_0000);
        rdc("irq", 8'h10, 32'h0000_0000);
        rdc("unmapped", 8'h14, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, er);
        apb(1'b1, 8'h04, 32'h0000_1234);
        rdc("a halted", 8'h04, 32'h0000_1234);
        apb(1'b1, 8'h08, 32'h0000_0010);
        apb(1'b1, 8'h00, 32'h0000_0002);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk("b live", 32'h0000_0001, rd <= 32'h0000_0010 || rd == 32'h0000_FFFF);
        apb(1'b1, 8'h00, 32'h0000_0000);
        apb(1'b1, 8'h04, 32'h0000_0010);
        apb(1'b1, 8'h00, 32'h0000_0001);
        // Reads three cycles apart land once on every phase of the 17-tick
        // period, so exactly one of them meets the reload instant.
        for (int i = 0; i < 17; i++) begin
            apb(1'b0, 8'h04, 32'h0000_0000);
            hits += (rd == 32'h0000_FFFF);
            chk("a live", 32'h0000_0001,
                (rd != 32'h0000_0000 && rd <= 32'h0000_0010) || rd == 32'h0000_FFFF);
        end
        chk("a reload reads", 32'h0000_0001, hits);
        apb(1'b1, 8'h00, 32'h0000_0000);
        apb(1'b0, 8'h04, 32'h0000_0000);
        v = rd;
        rdc("a halt", 8'h04, v);
        foreach (mt[i]) begin
            apb(1'b1, 8'h00, {24'h00_0000, mt[i][15:8]});
            apb(1'b1, 8'h10, 32'h0000_0003);
            apb(1'b1, 8'h00, {24'h00_0000, mt[i][7:0]});
            settle();
            chk("mode irq", 32'h0000_0001, a_irq);
            apb(1'b1, 8'h10, 32'h0000_0001);
            settle();
            chk("irq clear", 32'h0000_0000, a_irq);
        end
        apb(1'b1, 8'h00, 32'h0000_0008);
        apb(1'b1, 8'h04, 32'h0000_0100);
        apb(1'b1, 8'h00, 32'h0000_0009);
        wait_out();
        apb(1'b1, 8'h00, 32'h0000_0008);
        settle();
        chk("shot pin", 32'h0000_0000, out_pin);
        chk("shot irq", 32'h0000_0001, a_irq);
        rdc("shot reload", 8'h04, 32'h0000_0100);
        apb(1'b1, 8'h04, 32'h0000_FFFF);
        apb(1'b1, 8'h00, 32'h0000_000D);
        apb(1'b1, 8'h10, 32'h0000_0001);
        wait_out();
        apb(1'b1, 8'h00, 32'h0000_000C);
        settle();
        chk("pwm hi pin", 32'h0000_0000, out_pin);
        chk("pwm hi irq", 32'h0000_0001, a_irq);
        apb(1'b1, 8'h04, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_000D);
        apb(1'b1, 8'h10, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_000C);
        settle();
        chk("pwm lo pin", 32'h0000_0000, out_pin);
        chk("pwm lo irq", 32'h0000_0000, a_irq);
        apb(1'b1, 8'h00, 32'h0000_0004);
        apb(1'b1, 8'h04, 32'h0000_0005);
        apb(1'b1, 8'h00, 32'h0000_0005);
        pulse(1'b0);
        pulse(1'b0);
        rdc("a events", 8'h04, 32'h0000_0003);
        // Free-running count is rewritten after the stop, before restart.
        apb(1'b1, 8'h00, 32'h0000_0084);
        apb(1'b1, 8'h04, 32'h0000_0005);
        apb(1'b1, 8'h00, 32'h0000_0085);
        pulse(1'b0);
        rdc("a free", 8'h04, 32'h0000_0004);
        // Up-count overflow: the read setup edge meets the counted edge.
        apb(1'b1, 8'h00, 32'h0000_0044);
        apb(1'b1, 8'h04, 32'h0000_FFFF);
        apb(1'b1, 8'h00, 32'h0000_0045);
        @(posedge sys_clk);
        a_pin <= 1'b1;
        @(posedge sys_clk);
        rdc("a overflow", 8'h04, 32'h0000_0000);
        a_pin <= 1'b0;
        apb(1'b1, 8'h00, 32'h0000_0020);
        apb(1'b1, 8'h00, 32'h0000_0022);
        apb(1'b1, 8'h10, 32'h0000_0003);
        pulse(1'b1);
        chk("first edge", 32'h0000_0000, b_irq);
        pulse(1'b1);
        chk("next edge", 32'h0000_0001, b_irq);
        apb(1'b1, 8'h10, 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_0032);
        settle();
        chk("b select", 32'h0000_0001, b_irq);
        wrap_up();
    end
    // Cuts a hang short well past the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        wrap_up();
    end
endmodule // mta_timer_ab_bench
bind mta_timer_ab mta_timer_ab_checker chk_i (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .group_a_timer_output_pin(group_a_timer_output_pin),
    .a_irq_req(a_irq_req), .b_irq_req(b_irq_req));
`default_nettype wire
